// ---- core/npic_pkg.sv ----
// npic_pkg: constants and carrier types for the nand pin host controller
package npic_pkg;

  // ----------------------------------------------------------------
  // bus widths and queue depth
  // ----------------------------------------------------------------
  localparam int IO_W_X8   = 8;
  localparam int IO_W_X16  = 16;
  localparam int IO_W      = IO_W_X16;
  localparam int FIFO_DEP  = 16;

  // ----------------------------------------------------------------
  // timing: strobe phases and ready/busy wait
  // ----------------------------------------------------------------
  localparam int CLK_PS       = 10000;
  localparam int T_SETUP_NS   = 20;
  localparam int T_PULSE_NS   = 20;
  localparam int T_HOLD_NS    = 20;
  localparam int T_RB_WAIT_NS = 100;
  localparam int C_SETUP   = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_PULSE   = (T_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_HOLD    = (T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int C_RB_WAIT = (T_RB_WAIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W     = 5;

  // ----------------------------------------------------------------
  // request kinds and carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NPIC_CMD  = 2'h0,
    NPIC_ADDR = 2'h1,
    NPIC_WDAT = 2'h2,
    NPIC_RDAT = 2'h3
  } npic_kind_t;

  typedef struct packed {
    npic_kind_t        kind;
    logic              wait_rb;
    logic [IO_W-1:0]   data;
  } npic_req_t;

  localparam int REQ_W = $bits(npic_req_t);

endpackage

// ---- core/npic_fifo.sv ----
// npic_fifo: parameterised valid/ready fifo for the request path
`timescale 1ns/1ps
module npic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // flags and handshakes
  // ----------------------------------------------------------------
  // full at exactly DEPTH entries; compare at occupancy width
  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ---- core/npic_host.sv ----
// npic_host: host-side pin sequencer for a multiplexed nand flash port
`timescale 1ns/1ps
// Function
// - shared bus carries command, address, data
// - command byte with command latch high
// - address byte with address latch high
// - ready/busy open drain, needs pull-up
// - write strobe pulse latched on rise
// - address cycles low bits first, column first
// - one or two command cycles per operation
module npic_host (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  // configuration
  input  wire logic                       i_wide,
  input  wire logic                       i_write_protect_n,
  // request stream in
  input  wire logic                       i_req_valid,
  input  wire npic_pkg::npic_req_t        i_req,
  output logic                            o_req_ready,
  // read data out
  output logic                            o_rd_valid,
  output logic [npic_pkg::IO_W-1:0]       o_rd_data,
  // status
  output logic                            o_busy,
  output logic                            o_dev_ready,
  // nand pins
  output logic                            o_chip_sel_n,
  output logic                            o_cmd_latch,
  output logic                            o_addr_latch,
  output logic                            o_write_strobe_n,
  output logic                            o_read_strobe_n,
  output logic                            o_write_prot_n,
  output logic [npic_pkg::IO_W-1:0]       o_shared_io_bus,
  output logic                            o_shared_io_bus_oe_n,
  input  wire logic [npic_pkg::IO_W-1:0]  i_shared_io_bus,
  input  wire logic                       i_ready_busy_n
);

  typedef enum logic [2:0] {
    NPIC_IDLE, NPIC_SETUP, NPIC_PULSE, NPIC_HOLD, NPIC_RBWAIT
  } npic_state_t;

  npic_state_t                     state_reg, state_next;
  logic [npic_pkg::CNT_W-1:0]      cnt_reg, cnt_next;
  npic_pkg::npic_req_t             cur_reg;
  logic                            q_valid;
  npic_pkg::npic_req_t             q_data;
  logic                            q_take;
  logic                            is_read;
  logic                            is_write;
  logic                            cnt_done;
  logic [npic_pkg::IO_W-1:0]       io_mask;
  logic [npic_pkg::IO_W-1:0]       rd_sync1_reg, rd_sync2_reg;
  logic                            rb_sync1_reg, rb_sync2_reg;
  logic                            rd_valid_reg;
  logic [npic_pkg::IO_W-1:0]       rd_data_reg;

  // ----------------------------------------------------------------
  // request queue
  // ----------------------------------------------------------------
  npic_fifo #(
    .WIDTH (npic_pkg::REQ_W),
    .DEPTH (npic_pkg::FIFO_DEP)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (i_req_valid),
    .i_in_data   (i_req),
    .o_in_ready  (o_req_ready),
    .o_out_valid (q_valid),
    .o_out_data  (q_data),
    .i_out_ready (q_take)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign q_take   = (state_reg == NPIC_IDLE) && q_valid;
  assign is_read  = (cur_reg.kind == npic_pkg::NPIC_RDAT);
  assign is_write = !is_read;
  assign cnt_done = (cnt_reg == '0);
  // narrow part: upper lanes held low
  assign io_mask  = i_wide ? {npic_pkg::IO_W{1'b1}}
                           : {{(npic_pkg::IO_W-npic_pkg::IO_W_X8){1'b0}},
                              {npic_pkg::IO_W_X8{1'b1}}};

  // ----------------------------------------------------------------
  // two-flop synchronisers for device pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_sync1_reg <= '0;
      rd_sync2_reg <= '0;
      rb_sync1_reg <= 1'b0;
      rb_sync2_reg <= 1'b0;
    end else begin
      rd_sync1_reg <= i_shared_io_bus;
      rd_sync2_reg <= rd_sync1_reg;
      rb_sync1_reg <= i_ready_busy_n;   // pulled high externally
      rb_sync2_reg <= rb_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!cnt_done) begin
      cnt_next = cnt_reg - 1'b1;
    end
    unique case (state_reg)
      NPIC_IDLE: begin
        if (q_valid) begin
          state_next = NPIC_SETUP;
          cnt_next   = npic_pkg::CNT_W'(npic_pkg::C_SETUP);
        end
      end
      NPIC_SETUP: begin
        if (cnt_done) begin
          state_next = NPIC_PULSE;
          cnt_next   = npic_pkg::CNT_W'(npic_pkg::C_PULSE);
        end
      end
      NPIC_PULSE: begin
        if (cnt_done) begin
          state_next = NPIC_HOLD;
          cnt_next   = npic_pkg::CNT_W'(npic_pkg::C_HOLD);
        end
      end
      NPIC_HOLD: begin
        if (cnt_done) begin
          if (cur_reg.wait_rb) begin
            state_next = NPIC_RBWAIT;   // execute cycle
            cnt_next   = npic_pkg::CNT_W'(npic_pkg::C_RB_WAIT);
          end else begin
            state_next = NPIC_IDLE;
          end
        end
      end
      NPIC_RBWAIT: begin
        // busy drop may lag; then wait for release
        if (cnt_done && rb_sync2_reg) begin
          state_next = NPIC_IDLE;
        end
      end
      // unused state codes fall back to idle
      default: begin
        state_next = NPIC_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= NPIC_IDLE;
      cnt_reg   <= '0;
      cur_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (q_take) cur_reg <= q_data;
    end
  end

  // ----------------------------------------------------------------
  // read capture at end of read strobe pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end else begin
      rd_valid_reg <= 1'b0;
      if (state_reg == NPIC_PULSE && cnt_done && is_read) begin
        rd_valid_reg <= 1'b1;
        rd_data_reg  <= rd_sync2_reg & io_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic active;
  assign active = (state_reg == NPIC_SETUP) || (state_reg == NPIC_PULSE)
                  || (state_reg == NPIC_HOLD);

  // select held through the whole cycle
  assign o_chip_sel_n = !(active || state_reg == NPIC_RBWAIT);
  // only one latch strobe, none for data
  assign o_cmd_latch  = active && (cur_reg.kind == npic_pkg::NPIC_CMD);
  assign o_addr_latch = active && (cur_reg.kind == npic_pkg::NPIC_ADDR);
  // rising edge at pulse end latches
  assign o_write_strobe_n = !((state_reg == NPIC_PULSE) && is_write);
  // each fall steps device column
  assign o_read_strobe_n  = !((state_reg == NPIC_PULSE) && is_read);
  // drive bus only for writes; device floats otherwise
  assign o_shared_io_bus_oe_n = !(active && is_write);
  // caller orders address bytes low first, column first
  assign o_shared_io_bus  = cur_reg.data & io_mask;
  assign o_write_prot_n   = i_write_protect_n;
  assign o_busy      = (state_reg != NPIC_IDLE) || q_valid;
  assign o_dev_ready = rb_sync2_reg;
  assign o_rd_valid  = rd_valid_reg;
  assign o_rd_data   = rd_data_reg;

endmodule

// ---- verification/npic_host_checker.sv ----
// npic_host_checker: pin protocol assertions for the nand host
`timescale 1ns/1ps
module npic_host_checker (
  // clock, reset and configuration
  input wire logic                      i_clk,
  input wire logic                      i_reset,
  input wire logic                      i_wide,
  input wire logic                      i_write_protect_n,
  // read side and nand pins
  input wire logic                      o_rd_valid,
  input wire logic                      o_chip_sel_n,
  input wire logic                      o_cmd_latch,
  input wire logic                      o_addr_latch,
  input wire logic                      o_write_strobe_n,
  input wire logic                      o_read_strobe_n,
  input wire logic                      o_write_prot_n,
  input wire logic [npic_pkg::IO_W-1:0] o_shared_io_bus,
  input wire logic                      o_shared_io_bus_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // pin relations
  // ----------------------------------------------------------------
  property p_one_latch; !(o_cmd_latch && o_addr_latch); endproperty
  a_one_latch: assert property (p_one_latch)
    else $error("both latch strobes high");
  property p_wp; o_write_prot_n == i_write_protect_n; endproperty
  a_wp: assert property (p_wp)
    else $error("write protect pin differs from input");
  property p_sel;
    (!o_write_strobe_n || !o_read_strobe_n) |-> !o_chip_sel_n;
  endproperty
  a_sel: assert property (p_sel)
    else $error("strobe low while deselected");
  property p_rd_float; !o_read_strobe_n |-> o_shared_io_bus_oe_n; endproperty
  a_rd_float: assert property (p_rd_float)
    else $error("host drives bus during read strobe");
  property p_wr_pulse;
    $fell(o_write_strobe_n) |-> !o_write_strobe_n [*3] ##1 o_write_strobe_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe pulse not three cycles");
  property p_wr_hold;
    $rose(o_write_strobe_n) |-> $stable(o_shared_io_bus) && !o_chip_sel_n
      && $stable({o_cmd_latch, o_addr_latch});
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("bus or latches moved at write strobe rise");
  property p_rd_pulse; $rose(o_read_strobe_n) |-> o_rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("no read data at read strobe rise");
  property p_narrow;
    (!i_wide && !o_shared_io_bus_oe_n) |-> o_shared_io_bus[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("upper bus bits driven in narrow mode");
  // main scenarios seen
  c_cmd: cover property ($fell(o_write_strobe_n) && o_cmd_latch);
  c_addr: cover property ($fell(o_write_strobe_n) && o_addr_latch);
  c_read: cover property (o_rd_valid);
endmodule

// ---- verification/npic_dev_model.sv ----
// npic_dev_model: behavioural nand device facing the host pins
`timescale 1ns/1ps
module npic_dev_model #(
  parameter logic [7:0] EXEC_CMD = 8'h10,
  parameter int         BUSY_NS  = 400
) (
  // strobes and bus from the host
  input  wire logic        i_chip_sel_n,
  input  wire logic        i_cmd_latch,
  input  wire logic        i_addr_latch,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_write_prot_n,
  input  wire logic [15:0] i_bus,
  // answers to the host
  output logic      [15:0] o_bus,
  output logic             o_rb_low
);
  logic [15:0] cmd_reg = 16'h0000;
  logic [15:0] addr_reg = 16'h0000;
  logic [15:0] data_reg = 16'h0000;
  logic [15:0] col_reg = 16'h0000;
  logic [15:0] out_q = 16'h0000;
  initial o_rb_low = 1'b0;
  // latch cycles on write strobe rise; start busy is ignored when protected
  always @(posedge i_write_strobe_n) begin
    if (!i_chip_sel_n && i_cmd_latch) begin
      cmd_reg = i_bus;
      if (i_bus[7:0] == EXEC_CMD && i_write_prot_n) begin
        o_rb_low = 1'b1;
        o_rb_low <= #(BUSY_NS) 1'b0;
      end
    end else if (!i_chip_sel_n && i_addr_latch) begin
      addr_reg = i_bus;
      col_reg = i_bus;
    end else if (!i_chip_sel_n) begin
      data_reg = i_bus;
    end
  end
  // present current column, then advance the counter
  always @(negedge i_read_strobe_n) begin
    out_q = {8'hC3, col_reg[7:0]};
    col_reg = col_reg + 16'h0001;
  end
  // released bus shows the inverse so stale data never passes
  assign o_bus = (!i_chip_sel_n && !i_read_strobe_n) ? out_q : ~out_q;
endmodule

// ---- verification/npic_host_tb.sv ----
// npic_host_tb: self-checking bench for the nand host controller
`timescale 1ns/1ps
module npic_host_tb;
  logic                clk = 1'b0, rst = 1'b1, wide = 1'b1, wp_n = 1'b1;
  logic                vld = 1'b0, rdy, rdv, busy, devr, cs_n, cmd_l, adr_l;
  logic                we_n, re_n, wpo_n, oe_n, rb_low;
  logic [15:0]         rdd, hbus, dbus;
  logic [15:0]         rdq[$];
  npic_pkg::npic_req_t req = '0;
  int                  num_errors = 0, num_checks = 0;
  always #5 clk = ~clk;
  // design and device model; ready/busy has a pull-up
  npic_host dut (
    .i_clk(clk), .i_reset(rst), .i_wide(wide), .i_write_protect_n(wp_n),
    .i_req_valid(vld), .i_req(req), .o_req_ready(rdy), .o_rd_valid(rdv),
    .o_rd_data(rdd), .o_busy(busy), .o_dev_ready(devr), .o_chip_sel_n(cs_n),
    .o_cmd_latch(cmd_l), .o_addr_latch(adr_l), .o_write_strobe_n(we_n),
    .o_read_strobe_n(re_n), .o_write_prot_n(wpo_n), .o_shared_io_bus(hbus),
    .o_shared_io_bus_oe_n(oe_n), .i_shared_io_bus(dbus),
    .i_ready_busy_n(rb_low ? 1'b0 : 1'b1));
  npic_dev_model u_dev (
    .i_chip_sel_n(cs_n), .i_cmd_latch(cmd_l), .i_addr_latch(adr_l),
    .i_write_strobe_n(we_n), .i_read_strobe_n(re_n), .i_write_prot_n(wpo_n),
    .i_bus(hbus), .o_bus(dbus), .o_rb_low(rb_low));
  // read pulse stands a whole cycle, so sample it mid-cycle
  always @(negedge clk) if (rdv === 1'b1) rdq.push_back(rdd);
  task automatic chk(input string nm, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send(input npic_pkg::npic_kind_t k, input logic w,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    if (rdy !== 1'b1) begin num_errors++; finish_test(); end
    req = '{kind: k, wait_rb: w, data: d};
    vld = 1'b1;
    @(negedge clk) vld = 1'b0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (busy !== 1'b0 && n < 2000);
    if (busy !== 1'b0) begin num_errors++; finish_test(); end
  endtask
  task automatic t_write();
    send(npic_pkg::NPIC_CMD, 1'b0, 16'h00A5);
    send(npic_pkg::NPIC_ADDR, 1'b0, 16'h0030);
    send(npic_pkg::NPIC_WDAT, 1'b0, 16'h5A3C);
    idle();
    chk("cmd", u_dev.cmd_reg, 16'h00A5);
    chk("addr", u_dev.addr_reg, 16'h0030);
    chk("wdata", u_dev.data_reg, 16'h5A3C);
  endtask
  task automatic t_read(input logic w);
    wide = w;
    rdq.delete();
    // narrow mode offers dirty upper bits that the host must clear
    send(npic_pkg::NPIC_ADDR, 1'b0, w ? 16'h0030 : 16'hFF30);
    repeat (3) send(npic_pkg::NPIC_RDAT, 1'b0, 16'h0000);
    idle();
    chk("rd addr", u_dev.addr_reg, 16'h0030);
    chk("reads", 16'(rdq.size()), 16'h0003);
    foreach (rdq[i])
      chk("rdata", rdq[i], {w ? 8'hC3 : 8'h00, 8'h30 + 8'(i)});
  endtask
  task automatic t_busy(input logic wp);
    wp_n = wp;
    send(npic_pkg::NPIC_CMD, 1'b1, 16'h0010);
    repeat (20) @(negedge clk);
    chk("rb mid", {15'h0000, devr}, {15'h0000, ~wp});
    idle();
    chk("rb end", {15'h0000, devr}, 16'h0001);
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    @(negedge clk);
    req = '{kind: npic_pkg::NPIC_WDAT, wait_rb: 1'b0, data: 16'h0077};
    vld = 1'b1;
    while (rdy === 1'b1 && n < 40) begin @(negedge clk); n++; end
    vld = 1'b0;
    chk("refused", {15'h0000, rdy}, 16'h0000);
    idle();
    chk("drained", {15'h0000, rdy}, 16'h0001);
    chk("fill data", u_dev.data_reg, 16'h0077);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_write();
    t_read(1'b1);
    t_read(1'b0);
    t_busy(1'b1);
    t_busy(1'b0);
    t_fill();
    finish_test();
  end
endmodule
bind npic_host npic_host_checker u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_wide(i_wide),
  .i_write_protect_n(i_write_protect_n), .o_rd_valid(o_rd_valid),
  .o_chip_sel_n(o_chip_sel_n), .o_cmd_latch(o_cmd_latch),
  .o_addr_latch(o_addr_latch), .o_write_strobe_n(o_write_strobe_n),
  .o_read_strobe_n(o_read_strobe_n), .o_write_prot_n(o_write_prot_n),
  .o_shared_io_bus(o_shared_io_bus),
  .o_shared_io_bus_oe_n(o_shared_io_bus_oe_n));
